// file: hcf_capability_fields.sv
// Function
// - Bits 23:20 report maximum link speed generation.
// - Bit 18 set means native registers only.
// - Bit 17 reports command-based port multiplier support.
// - Frame switching only reported with multiplier support.
// - Bit 15 multi-block PIO, forced to one.
// - Bit 14 reports deep sleep capability.
// - Bit 13 reports light sleep capability.
// - Bits 12:8 slot count minus one.
// - Bit 7 set only with coalescing registers present.
// - Bit 6 set only with enclosure registers present.
// - Bit 5 set when any implemented port is external.
// - Bits 4:0 silicon port count minus one.
// - Port count may exceed implemented bitmap.
// - Reserved bits and unmapped locations read zero.
`timescale 1ns/1ns
`default_nettype none

module hcf_capability_fields #(
  parameter logic [3:0]  MAX_LINK_SPEED  = 4'h2,
  parameter logic        NATIVE_ONLY     = 1'b1,
  parameter logic        MULTIPLIER      = 1'b1,
  parameter logic        FRAME_SWITCHING = 1'b0,
  parameter logic        DEEP_SLEEP      = 1'b1,
  parameter logic        LIGHT_SLEEP     = 1'b1,
  parameter logic [4:0]  SLOTS_MINUS_ONE = 5'h1f,
  parameter logic        COALESCING      = 1'b0,
  parameter logic        ENCLOSURE_MGMT  = 1'b0,
  parameter logic [4:0]  PORTS_MINUS_ONE = 5'h03,
  parameter logic [31:0] PORT_BITMAP     = 32'h0000_000f,
  parameter logic [31:0] EXTERNAL_PORTS  = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  // Host register access
  input  wire logic [12:0]              regAddr,
  input  wire logic                     regRead,
  input  wire logic                     regWrite,
  input  wire logic [31:0]              regWriteData,
  output var  logic [31:0]              readData,
  output var  logic                     readValid,
  // Capability view for the rest of the adapter
  output var  hcf_pkg::hcf_caps_type    adapterCapabilities,
  output var  logic [31:0]              implementedPortBitmap,
  output var  logic [31:0]              portExternalFlag,
  output var  logic                     coalescingRegsPresent,
  output var  logic                     enclosureRegsPresent,
  output var  logic                     deepSleepAllowed,
  output var  logic                     lightSleepAllowed
);

  hcf_pkg::hcf_state_type state;
  hcf_pkg::hcf_state_type next_state;
  hcf_pkg::hcf_caps_type  capsImage;
  logic [31:0]            portInSilicon;
  logic [31:0]            bitmapImage;
  logic [31:0]            externalImage;
  logic                   capSelected;

  // Ports beyond the silicon count can never be implemented or external
  genvar port;
  generate
    for (port = 0; port < hcf_pkg::MAX_PORTS; port++) begin : g_port
      assign portInSilicon[port] = (5'(port) <= PORTS_MINUS_ONE);
      assign bitmapImage[port]   = PORT_BITMAP[port] & portInSilicon[port];
      assign externalImage[port] = EXTERNAL_PORTS[port] & bitmapImage[port];
    end
  endgenerate

  // Capability image, sanitised so an odd parameter set cannot break the encoding
  always_comb begin
    capsImage                       = '0;
    capsImage.upperCaps             = hcf_pkg::UPPER_CAP_VALUE;
    // Reserved codes fall back to the slowest generation rather than read as garbage
    if ((MAX_LINK_SPEED >= hcf_pkg::SPEED_GEN1) && (MAX_LINK_SPEED <= hcf_pkg::SPEED_GEN3)) begin
      capsImage.maxLinkSpeed        = MAX_LINK_SPEED;
    end else begin
      capsImage.maxLinkSpeed        = hcf_pkg::SPEED_GEN1;
    end
    capsImage.reservedZero          = 1'b0;
    capsImage.nativeOnlySupport     = NATIVE_ONLY;
    capsImage.multiplierSupport     = MULTIPLIER;
    capsImage.frameSwitchingSupport = FRAME_SWITCHING & MULTIPLIER;
    capsImage.multiBlockPioSupport  = 1'b1;
    capsImage.deepSleepCapable      = DEEP_SLEEP;
    capsImage.lightSleepCapable     = LIGHT_SLEEP;
    capsImage.slotCountMinusOne     = SLOTS_MINUS_ONE;
    capsImage.coalescingSupport     = COALESCING;
    capsImage.enclosureMgmtSupport  = ENCLOSURE_MGMT;
    capsImage.externalConnectorSupport = |externalImage;
    capsImage.portCountMinusOne     = PORTS_MINUS_ONE;
  end

  assign capSelected = (regAddr[12:2] == hcf_pkg::CAP_OFFSET[12:2]);

  always_comb begin
    next_state           = state;
    next_state.readValid = 1'b0;
    if (rst) begin
      next_state.adapterCapabilities   = capsImage;
      next_state.implementedPortBitmap = bitmapImage;
      next_state.portExternalFlag      = externalImage;
      next_state.readData              = hcf_pkg::UNMAPPED_VALUE;
    end else if (regRead) begin
      next_state.readValid = 1'b1;
      if (capSelected) begin
        next_state.readData = state.adapterCapabilities;
      end else begin
        next_state.readData = hcf_pkg::UNMAPPED_VALUE;
      end
    end
    // Writes are accepted and dropped; nothing here is writable
  end

  always_ff @(posedge core_clk) begin
    state <= next_state;
  end

  assign readData              = state.readData;
  assign readValid             = state.readValid;
  assign adapterCapabilities   = state.adapterCapabilities;
  assign implementedPortBitmap = state.implementedPortBitmap;
  assign portExternalFlag      = state.portExternalFlag;
  // Gates the optional register groups elsewhere in the adapter
  assign coalescingRegsPresent = state.adapterCapabilities.coalescingSupport;
  assign enclosureRegsPresent  = state.adapterCapabilities.enclosureMgmtSupport;
  // Power control logic must not start transitions the link cannot take
  assign deepSleepAllowed      = state.adapterCapabilities.deepSleepCapable;
  assign lightSleepAllowed     = state.adapterCapabilities.lightSleepCapable;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_cap_read;
    regRead && capSelected;
  endsequence

  sequence s_cap_answer;
    readValid && (readData == $past(state.adapterCapabilities));
  endsequence

  sequence s_no_read;
    !regRead;
  endsequence

  a_speed_legal: assert property (
    (adapterCapabilities.maxLinkSpeed >= hcf_pkg::SPEED_GEN1) &&
    (adapterCapabilities.maxLinkSpeed <= hcf_pkg::SPEED_GEN3))
    else $error("link speed code is reserved");

  a_native_only: assert property (
    adapterCapabilities.nativeOnlySupport == NATIVE_ONLY)
    else $error("native only bit differs from implementation");

  a_frame_needs_mult: assert property (
    adapterCapabilities.frameSwitchingSupport |-> adapterCapabilities.multiplierSupport)
    else $error("frame switching without multiplier support");

  a_multi_pio: assert property (
    adapterCapabilities.multiBlockPioSupport)
    else $error("multi block pio bit clear");

  a_sleep_gates: assert property (
    (deepSleepAllowed == adapterCapabilities.deepSleepCapable) &&
    (lightSleepAllowed == adapterCapabilities.lightSleepCapable))
    else $error("sleep permission differs from capability");

  a_optional_regs: assert property (
    (coalescingRegsPresent == adapterCapabilities.coalescingSupport) &&
    (enclosureRegsPresent == adapterCapabilities.enclosureMgmtSupport))
    else $error("optional register presence differs from capability");

  a_external_any: assert property (
    adapterCapabilities.externalConnectorSupport == (|portExternalFlag))
    else $error("external connector bit inconsistent");

  a_bitmap_within: assert property (
    (implementedPortBitmap & ~portInSilicon) == hcf_pkg::NO_PORTS)
    else $error("implemented port beyond silicon count");

  a_reserved_zero: assert property (
    !adapterCapabilities.reservedZero && (adapterCapabilities.upperCaps == hcf_pkg::UPPER_CAP_VALUE))
    else $error("reserved capability bit set");

  a_cap_read: assert property (
    s_cap_read |=> s_cap_answer)
    else $error("capability read answer wrong");

  a_unmapped_zero: assert property (
    regRead && !capSelected |=> readValid && (readData == hcf_pkg::UNMAPPED_VALUE))
    else $error("unmapped read not zero");

  a_write_stable: assert property (
    regWrite |=> $stable(adapterCapabilities) [*2])
    else $error("write changed capability bits");

  a_slots_ports: assert property (
    (adapterCapabilities.slotCountMinusOne == SLOTS_MINUS_ONE) &&
    (adapterCapabilities.portCountMinusOne == PORTS_MINUS_ONE))
    else $error("slot or port count differs from implementation");

  a_multiplier_value: assert property (
    adapterCapabilities.multiplierSupport == MULTIPLIER)
    else $error("multiplier bit differs from implementation");

  a_external_in_map: assert property (
    (portExternalFlag & ~implementedPortBitmap) == hcf_pkg::NO_PORTS)
    else $error("external port outside implemented map");

  // The image is loaded in reset and must never move afterwards
  a_image_stable: assert property (
    1'b1 |=> $stable(adapterCapabilities))
    else $error("capability image changed");

  // A stale answer would hand software a word it never asked for
  a_no_spurious: assert property (
    s_no_read |=> !readValid)
    else $error("answer without a read");

  a_read_hold: assert property (
    s_no_read |=> $stable(readData))
    else $error("read data moved without a read");

endmodule : hcf_capability_fields

`default_nettype wire

// file: hcf_capability_fields_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module hcf_capability_fields_tb_top;
  localparam logic [31:0] EXP_CAP = 32'h0027_bfa3;
  logic                  core_clk;
  logic                  rst;
  logic [12:0]           regAddr;
  logic                  regRead;
  logic                  regWrite;
  logic [31:0]           regWriteData;
  logic [31:0]           readData;
  logic                  readValid;
  hcf_pkg::hcf_caps_type adapterCapabilities;
  logic [31:0]           implementedPortBitmap;
  logic [31:0]           portExternalFlag;
  logic                  coalRegs;
  logic                  encRegs;
  logic                  deepOk;
  logic                  lightOk;
  logic [31:0]           capWord;
  logic [12:0]           holes [6];
  int                    errorCnt;
  int                    cmpCount;
  int                    cycleCnt = 0;

  // Map and external bits beyond the silicon count show the masking
  hcf_capability_fields #(
    .FRAME_SWITCHING(1'b1), .DEEP_SLEEP(1'b0), .COALESCING(1'b1),
    .PORT_BITMAP(32'h0000_0035), .EXTERNAL_PORTS(32'h0000_0024)
  ) i_hcf_capability_fields (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
    .regWriteData(regWriteData), .readData(readData), .readValid(readValid),
    .adapterCapabilities(adapterCapabilities), .implementedPortBitmap(implementedPortBitmap),
    .portExternalFlag(portExternalFlag), .coalescingRegsPresent(coalRegs),
    .enclosureRegsPresent(encRegs), .deepSleepAllowed(deepOk), .lightSleepAllowed(lightOk)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : giveVerdict

  task automatic rd(input logic [12:0] addr, output logic [31:0] data);
    @(negedge core_clk);
    regAddr = addr;
    regRead = 1'b1;
    @(negedge core_clk);
    regRead = 1'b0;
    chk("readValid", 32'h1, {31'h0, readValid});
    data = readData;
  endtask : rd

  task automatic wr(input logic [12:0] addr, input logic [31:0] data);
    @(negedge core_clk);
    regAddr = addr;
    regWriteData = data;
    regWrite = 1'b1;
    @(negedge core_clk);
    regWrite = 1'b0;
  endtask : wr

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Whole run needs about 50 cycles
  always @(posedge core_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 2000) begin
      errorCnt++;
      giveVerdict();
    end
  end

  initial begin
    rst = 1'b1;
    regAddr = 13'h0000;
    regRead = 1'b0;
    regWrite = 1'b0;
    regWriteData = 32'h0000_0000;
    errorCnt = 0;
    cmpCount = 0;
    holes = '{13'h0004, 13'h0014, 13'h001c, 13'h0020, 13'h0100, 13'h1ffc};
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    rd(13'h0000, capWord);
    chk("speed", 32'h2, {28'h0, capWord[23:20]});
    chk("bit19", 32'h0, {31'h0, capWord[19]});
    chk("nativeOnly", 32'h1, {31'h0, capWord[18]});
    chk("multiplier", 32'h1, {31'h0, capWord[17]});
    chk("frameSwitch", 32'h1, {31'h0, capWord[16]});
    chk("multiPio", 32'h1, {31'h0, capWord[15]});
    chk("deepSleep", 32'h0, {31'h0, capWord[14]});
    chk("lightSleep", 32'h1, {31'h0, capWord[13]});
    chk("slots", 32'h1f, {27'h0, capWord[12:8]});
    chk("coalescing", 32'h1, {31'h0, capWord[7]});
    chk("enclosure", 32'h0, {31'h0, capWord[6]});
    chk("external", 32'h1, {31'h0, capWord[5]});
    chk("ports", 32'h3, {27'h0, capWord[4:0]});
    chk("image", EXP_CAP, adapterCapabilities);
    chk("bitmap", 32'h0000_0005, implementedPortBitmap);
    chk("extFlags", 32'h0000_0004, portExternalFlag);
    chk("sideband", 32'h9, {28'h0, coalRegs, encRegs, deepOk, lightOk});
    $display("test fields done");
    wr(13'h0000, 32'hffff_ffff);
    wr(13'h0000, 32'h0000_0000);
    // Low address bits are ignored by the word decode
    rd(13'h0003, capWord);
    chk("afterWrite", EXP_CAP, capWord);
    chk("imageWrite", EXP_CAP, adapterCapabilities);
    $display("test writes done");
    foreach (holes[i]) begin
      wr(holes[i], 32'hffff_ffff);
      rd(holes[i], capWord);
      chk("unmapped", 32'h0, capWord);
    end
    $display("test unmapped done");
    @(negedge core_clk);
    regAddr = 13'h0004;
    regRead = 1'b1;
    @(negedge core_clk);
    regAddr = 13'h0000;
    chk("b2bFirst", 32'h0, readData);
    @(negedge core_clk);
    regRead = 1'b0;
    chk("b2bSecond", EXP_CAP, readData);
    chk("b2bValid", 32'h1, {31'h0, readValid});
    @(negedge core_clk);
    chk("validDrop", 32'h0, {31'h0, readValid});
    chk("dataHeld", EXP_CAP, readData);
    $display("test backtoback done");
    rst = 1'b1;
    regRead = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("resetNoAnswer", 32'h0, {31'h0, readValid});
    chk("resetData", 32'h0, readData);
    chk("resetImage", EXP_CAP, adapterCapabilities);
    regRead = 1'b0;
    rst = 1'b0;
    rd(13'h0000, capWord);
    chk("afterReset", EXP_CAP, capWord);
    $display("test reset done");
    giveVerdict();
  end
endmodule : hcf_capability_fields_tb_top

`default_nettype wire

// file: hcf_pkg.sv
`default_nettype none

package hcf_pkg;

  // Host register space layout
  localparam int unsigned          ADDR_WIDTH        = 13;
  localparam logic [12:0]          CAP_OFFSET        = 13'h0000;
  localparam logic [31:0]          UNMAPPED_VALUE    = 32'h0000_0000;

  // Field low bit positions
  localparam int unsigned          SPEED_LSB         = 20;
  localparam int unsigned          RESERVED_BIT      = 19;
  localparam int unsigned          SLOT_LSB          = 8;
  localparam int unsigned          PORT_LSB          = 0;

  // Link speed encodings
  localparam logic [3:0]           SPEED_GEN1        = 4'h1;
  localparam logic [3:0]           SPEED_GEN2        = 4'h2;
  localparam logic [3:0]           SPEED_GEN3        = 4'h3;

  localparam int unsigned          MAX_PORTS         = 32;
  localparam logic [7:0]           UPPER_CAP_VALUE   = 8'h00;
  localparam logic [31:0]          NO_PORTS          = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] upperCaps;
    logic [3:0] maxLinkSpeed;
    logic       reservedZero;
    logic       nativeOnlySupport;
    logic       multiplierSupport;
    logic       frameSwitchingSupport;
    logic       multiBlockPioSupport;
    logic       deepSleepCapable;
    logic       lightSleepCapable;
    logic [4:0] slotCountMinusOne;
    logic       coalescingSupport;
    logic       enclosureMgmtSupport;
    logic       externalConnectorSupport;
    logic [4:0] portCountMinusOne;
  } hcf_caps_type;

  typedef struct packed {
    hcf_caps_type adapterCapabilities;
    logic [31:0]  implementedPortBitmap;
    logic [31:0]  portExternalFlag;
    logic [31:0]  readData;
    logic         readValid;
  } hcf_state_type;

endpackage : hcf_pkg

`default_nettype wire
